//--- rtl/iod_pkg.sv
package iod_pkg;

    // Host bus shape
    localparam int ADDR_W = 10;
    localparam int DATA_W = 16;
    localparam int SEL_W = 5;
    localparam int BASE_W = ADDR_W - SEL_W;
    localparam int BASE_LSB = 5;

    // Decoded window
    localparam logic [SEL_W-1:0] WIN_FIRST = 5'h00;
    localparam logic [SEL_W-1:0] WIN_LAST = 5'h1b;
    localparam logic [ADDR_W-1:0] BASE_MIN = 10'h000;
    localparam logic [ADDR_W-1:0] BASE_MAX = 10'h3e0;

    // Status register
    localparam logic [SEL_W-1:0] OFS_STATUS = 5'h12;
    localparam int STATUS_W = 8;
    localparam int ST_OPT_LSB = 0;
    localparam int ST_OPT_W = 5;
    localparam int ST_FLAG_LSB = 5;
    localparam int ST_FLAG_W = 3;
    localparam logic [STATUS_W-1:0] RST_STATUS = 8'h00;

    // Other reset values
    localparam logic [DATA_W-1:0] RST_DATA = 16'h0000;
    localparam logic [SEL_W-1:0] RST_OFFSET = 5'h00;

    // Bus cycle sequencer
    typedef enum logic [1:0] {
        IOD_IDLE = 2'b00,
        IOD_RD = 2'b01,
        IOD_WR = 2'b10
    } iod_state_t;

endpackage : iod_pkg

//--- rtl/iod_sync2.sv
module iod_sync2 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic clock,
    input wire logic ce,
    input wire logic sys_rst,
    // Data
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] q_r;
    logic [WIDTH-1:0] q_nxt;

    generate
        if (WIDTH < 1) begin : g_chk
            $error("iod_sync2 width must be at least one");
        end
    endgenerate

    // Two-stage capture
    always_comb begin
        meta_nxt = meta_r;
        q_nxt = q_r;
        if (sys_rst) begin
            meta_nxt = RST_VAL;
            q_nxt = RST_VAL;
        end else if (ce) begin
            meta_nxt = d;
            q_nxt = meta_r;
        end
    end

    always_ff @(posedge clock) begin
        meta_r <= meta_nxt;
        q_r <= q_nxt;
    end

    assign q = q_r;

endmodule // iod_sync2

//--- rtl/iod_decoder.sv
// Operation
// - A fitted base jumper reads as 0, an absent one as 1.
// - Lowest base jumper compares with address line 5, highest with line 9.
// - After a base match, address lines 4 to 0 pick the internal register.
// - Claim the contiguous window from base through base plus 1B hex.
// - Base lies in 000 to 3E0 hex, on a 32-address boundary.
// - Jumper selections are readable as status at base plus 12 hex; the code returns only the option jumpers there, not the base jumpers.
module iod_decoder #(
    parameter int OPT_W = iod_pkg::ST_OPT_W,
    parameter int FLAG_W = iod_pkg::ST_FLAG_W
) (
    // Clock, enable, reset
    input wire logic clock,
    input wire logic ce,
    input wire logic sys_rst,
    // Host bus pins
    input wire logic [iod_pkg::ADDR_W-1:0] bus_addr,
    input wire logic bus_aen,
    input wire logic bus_ior_n,
    input wire logic bus_iow_n,
    input wire logic bus_sbhe_n,
    input wire logic [iod_pkg::DATA_W-1:0] bus_data_i,
    output logic [iod_pkg::DATA_W-1:0] bus_data_o,
    output logic bus_data_oe,
    output logic bus_io16_n_o,
    output logic bus_io16_n_oe,
    // Jumper pins, low when fitted
    input wire logic [iod_pkg::BASE_W-1:0] base_jmp_lvl,
    input wire logic [OPT_W-1:0] opt_jmp_lvl,
    // Flags from board logic
    input wire logic [FLAG_W-1:0] flag_bits,
    // Register side
    output logic board_sel,
    output logic [iod_pkg::SEL_W-1:0] reg_offset,
    output logic reg_word,
    output logic reg_rd_stb,
    output logic reg_wr_stb,
    output logic [iod_pkg::DATA_W-1:0] reg_wdata,
    input wire logic [iod_pkg::DATA_W-1:0] reg_rdata
);

    localparam int AW = iod_pkg::ADDR_W;
    localparam int DW = iod_pkg::DATA_W;
    localparam int SW = iod_pkg::SEL_W;
    localparam int BW = iod_pkg::BASE_W;
    localparam int PW = AW + 4 + DW + BW + OPT_W;
    localparam logic [PW-1:0] PIN_RST = {{AW{1'b0}}, 4'hf, {(PW-AW-4){1'b0}}};

    generate
        if (OPT_W + FLAG_W != iod_pkg::STATUS_W) begin : g_chk_status
            $error("status fields must fill the status register exactly");
        end
        if (BW + iod_pkg::BASE_LSB != AW) begin : g_chk_base
            $error("base field must reach the top address line");
        end
    endgenerate

    // Pin synchronisers
    logic [PW-1:0] pin_raw;
    logic [PW-1:0] pin_s;
    logic [AW-1:0] addr_s;
    logic aen_s;
    logic ior_n_s;
    logic iow_n_s;
    logic sbhe_n_s;
    logic [DW-1:0] data_s;
    logic [BW-1:0] base_lvl_s;
    logic [OPT_W-1:0] opt_lvl_s;

    assign pin_raw = {bus_addr, bus_aen, bus_ior_n, bus_iow_n, bus_sbhe_n,
                      bus_data_i, base_jmp_lvl, opt_jmp_lvl};

    iod_sync2 #(
        .WIDTH(PW),
        .RST_VAL(PIN_RST)
    ) u_pin_sync (
        .clock(clock),
        .ce(ce),
        .sys_rst(sys_rst),
        .d(pin_raw),
        .q(pin_s)
    );

    assign {addr_s, aen_s, ior_n_s, iow_n_s, sbhe_n_s, data_s, base_lvl_s, opt_lvl_s} = pin_s;

    // Address decode
    logic [BW-1:0] base_jmp_fitted;
    logic [BW-1:0] base_val;
    logic [AW-1:0] base_addr;
    logic [SW-1:0] addr_sel;
    logic base_hit;
    logic win_hit;
    logic word_acc;

    assign base_jmp_fitted = ~base_lvl_s;
    assign base_val = ~base_jmp_fitted;
    assign base_addr = {base_val, {iod_pkg::BASE_LSB{1'b0}}};
    assign base_hit = (addr_s[AW-1:iod_pkg::BASE_LSB] == base_addr[AW-1:iod_pkg::BASE_LSB]);
    assign addr_sel = addr_s[SW-1:0];
    assign win_hit = !aen_s && base_hit && (addr_sel >= iod_pkg::WIN_FIRST)
                     && (addr_sel <= iod_pkg::WIN_LAST);
    // Word only when the high lane is enabled at an even offset
    assign word_acc = !sbhe_n_s && !addr_sel[0];

    // Strobe edge history
    logic ior_n_q_r;
    logic ior_n_q_nxt;
    logic iow_n_q_r;
    logic iow_n_q_nxt;
    logic ior_fall;
    logic iow_fall;

    assign ior_fall = ior_n_q_r && !ior_n_s;
    assign iow_fall = iow_n_q_r && !iow_n_s;

    always_comb begin
        ior_n_q_nxt = ior_n_q_r;
        iow_n_q_nxt = iow_n_q_r;
        if (sys_rst) begin
            ior_n_q_nxt = 1'b1;
            iow_n_q_nxt = 1'b1;
        end else if (ce) begin
            ior_n_q_nxt = ior_n_s;
            iow_n_q_nxt = iow_n_s;
        end
    end

    always_ff @(posedge clock) begin
        ior_n_q_r <= ior_n_q_nxt;
        iow_n_q_r <= iow_n_q_nxt;
    end

    // Status register
    logic [iod_pkg::STATUS_W-1:0] status_r;
    logic [iod_pkg::STATUS_W-1:0] status_nxt;

    always_comb begin
        status_nxt = status_r;
        if (sys_rst) begin
            status_nxt = iod_pkg::RST_STATUS;
        end else if (ce) begin
            status_nxt[iod_pkg::ST_OPT_LSB +: OPT_W] = opt_lvl_s;
            status_nxt[iod_pkg::ST_FLAG_LSB +: FLAG_W] = flag_bits;
        end
    end

    always_ff @(posedge clock) begin
        status_r <= status_nxt;
    end

    // Bus cycle sequencer
    iod_pkg::iod_state_t state_r;
    iod_pkg::iod_state_t state_nxt;
    logic [SW-1:0] offset_r;
    logic [SW-1:0] offset_nxt;
    logic word_r;
    logic word_nxt;
    logic rd_stb_r;
    logic rd_stb_nxt;
    logic wr_stb_r;
    logic wr_stb_nxt;
    logic rd_vld_r;
    logic rd_vld_nxt;
    logic [DW-1:0] rdata_r;
    logic [DW-1:0] rdata_nxt;
    logic [DW-1:0] wdata_r;
    logic [DW-1:0] wdata_nxt;

    always_comb begin
        state_nxt = state_r;
        offset_nxt = offset_r;
        word_nxt = word_r;
        rd_stb_nxt = 1'b0;
        wr_stb_nxt = 1'b0;
        rd_vld_nxt = rd_vld_r;
        rdata_nxt = rdata_r;
        wdata_nxt = wdata_r;
        if (sys_rst) begin
            state_nxt = iod_pkg::IOD_IDLE;
            offset_nxt = iod_pkg::RST_OFFSET;
            word_nxt = 1'b0;
            rd_vld_nxt = 1'b0;
            rdata_nxt = iod_pkg::RST_DATA;
            wdata_nxt = iod_pkg::RST_DATA;
        end else if (!ce) begin
            rd_stb_nxt = rd_stb_r;
            wr_stb_nxt = wr_stb_r;
        end else begin
            case (state_r)
                iod_pkg::IOD_IDLE: begin
                    rd_vld_nxt = 1'b0;
                    if (ior_fall && win_hit) begin
                        state_nxt = iod_pkg::IOD_RD;
                        offset_nxt = addr_sel;
                        word_nxt = word_acc;
                        rd_stb_nxt = 1'b1;
                    end else if (iow_fall && win_hit) begin
                        state_nxt = iod_pkg::IOD_WR;
                        offset_nxt = addr_sel;
                        word_nxt = word_acc;
                    end
                end
                iod_pkg::IOD_RD: begin
                    if (rd_stb_r) begin
                        rd_vld_nxt = 1'b1;
                        rdata_nxt = reg_rdata;
                        if (offset_r == iod_pkg::OFS_STATUS) begin
                            rdata_nxt[iod_pkg::STATUS_W-1:0] = status_r;
                        end
                        if (!word_r) begin
                            rdata_nxt[DW-1:iod_pkg::STATUS_W] = '0;
                        end
                    end
                    if (ior_n_s) begin
                        state_nxt = iod_pkg::IOD_IDLE;
                        rd_vld_nxt = 1'b0;
                    end
                end
                iod_pkg::IOD_WR: begin
                    if (iow_n_s) begin
                        state_nxt = iod_pkg::IOD_IDLE;
                        wdata_nxt = word_r ? data_s : {8'h00, data_s[7:0]};
                        // Byte writes to the status offset are dropped; word writes there still strobe
                        wr_stb_nxt = word_r || (offset_r != iod_pkg::OFS_STATUS);
                    end
                end
                default: begin
                    state_nxt = iod_pkg::IOD_IDLE;
                    rd_vld_nxt = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        state_r <= state_nxt;
        offset_r <= offset_nxt;
        word_r <= word_nxt;
        rd_stb_r <= rd_stb_nxt;
        wr_stb_r <= wr_stb_nxt;
        rd_vld_r <= rd_vld_nxt;
        rdata_r <= rdata_nxt;
        wdata_r <= wdata_nxt;
    end

    // Outputs
    assign bus_data_o = rdata_r;
    assign bus_data_oe = (state_r == iod_pkg::IOD_RD) && rd_vld_r;
    assign bus_io16_n_o = 1'b0;
    assign bus_io16_n_oe = (state_r != iod_pkg::IOD_IDLE) && word_r;
    assign board_sel = (state_r != iod_pkg::IOD_IDLE);
    assign reg_offset = offset_r;
    assign reg_word = word_r;
    assign reg_rd_stb = rd_stb_r;
    assign reg_wr_stb = wr_stb_r;
    assign reg_wdata = wdata_r;

endmodule // iod_decoder

//--- dv/iod_decoder_assertions.sv
module iod_decoder_chk #(
    parameter int OPT_W = 5,
    parameter int FLAG_W = 3
) (
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Host bus
    input wire logic [iod_pkg::ADDR_W-1:0] bus_addr,
    input wire logic bus_aen,
    input wire logic [iod_pkg::DATA_W-1:0] bus_data_o,
    input wire logic bus_data_oe,
    // Jumpers and flags
    input wire logic [iod_pkg::BASE_W-1:0] base_jmp_lvl,
    input wire logic [OPT_W-1:0] opt_jmp_lvl,
    input wire logic [FLAG_W-1:0] flag_bits,
    // Register side
    input wire logic board_sel,
    input wire logic [iod_pkg::SEL_W-1:0] reg_offset,
    input wire logic reg_word,
    input wire logic reg_rd_stb
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    a_oe_claimed: assert property (bus_data_oe |-> board_sel)
        else $error("data driven outside a claimed cycle");
    a_base_match: assert property ($rose(board_sel) |-> bus_addr[9:5] == base_jmp_lvl)
        else $error("claim without base match");
    a_offset_sel: assert property ($rose(board_sel) |-> reg_offset == bus_addr[4:0])
        else $error("offset differs from low address");
    a_window_end: assert property ($rose(board_sel) |-> reg_offset <= 5'h1b)
        else $error("claim beyond window end");
    a_no_dma: assert property ($rose(board_sel) |-> !bus_aen)
        else $error("claim during dma cycle");
    a_rd_drive: assert property ($rose(board_sel) && reg_rd_stb |-> ##[1:3] bus_data_oe)
        else $error("read not driven");
    a_status_data: assert property (bus_data_oe && reg_offset == 5'h12 && !reg_word
        |-> bus_data_o == {8'h00, flag_bits, opt_jmp_lvl}) else $error("status data wrong");
    a_rd_pulse: assert property (reg_rd_stb |=> !reg_rd_stb ##1 !reg_rd_stb)
        else $error("read strobe too long");
endmodule // iod_decoder_chk

bind iod_decoder iod_decoder_chk #(.OPT_W(OPT_W), .FLAG_W(FLAG_W)) u_chk (
    .clock(clock), .sys_rst(sys_rst), .bus_addr(bus_addr), .bus_aen(bus_aen),
    .bus_data_o(bus_data_o), .bus_data_oe(bus_data_oe), .base_jmp_lvl(base_jmp_lvl),
    .opt_jmp_lvl(opt_jmp_lvl), .flag_bits(flag_bits), .board_sel(board_sel),
    .reg_offset(reg_offset), .reg_word(reg_word), .reg_rd_stb(reg_rd_stb));

//--- dv/iod_host_model.sv
module iod_host_model (
    // Clock
    input wire logic clock,
    // Host bus pins
    output logic [9:0] bus_addr,
    output logic bus_aen,
    output logic bus_ior_n,
    output logic bus_iow_n,
    output logic bus_sbhe_n,
    output logic [15:0] bus_data_i,
    input wire logic [15:0] bus_data_o,
    input wire logic bus_data_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        bus_addr = 10'h000;
        bus_aen = 1'b0;
        bus_ior_n = 1'b1;
        bus_iow_n = 1'b1;
        bus_sbhe_n = 1'b1;
        bus_data_i = 16'h0000;
    end
    task automatic setup(input logic [9:0] a, input logic word, input logic aen);
        @(posedge clock);
        #1;
        bus_addr = a;
        bus_aen = aen;
        bus_sbhe_n = !(word && !a[0]);
        @(posedge clock);
        #1;
    endtask
    task automatic rd(input logic [9:0] a, input logic word, input logic aen,
                      output logic [15:0] d, output logic oe);
        setup(a, word, aen);
        bus_ior_n = 1'b0;
        repeat (10) @(posedge clock);
        d = bus_data_o;
        oe = bus_data_oe;
        #1;
        bus_ior_n = 1'b1;
        repeat (6) @(posedge clock);
        #1;
    endtask
    task automatic wr(input logic [9:0] a, input logic word, input logic [15:0] d);
        setup(a, word, 1'b0);
        bus_data_i = d;
        bus_iow_n = 1'b0;
        repeat (10) @(posedge clock);
        #1;
        bus_iow_n = 1'b1;
        repeat (6) @(posedge clock);
        #1;
        bus_data_i = ~d;
    endtask
endmodule // iod_host_model

//--- dv/iod_decoder_tb.sv
module iod_decoder_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic [9:0] bus_addr, ba;
    logic bus_aen, bus_ior_n, bus_iow_n, bus_sbhe_n, bus_data_oe, board_sel, reg_word;
    logic reg_rd_stb, reg_wr_stb, rd_oe;
    logic io16_o, io16_oe;
    logic [1:0] io16_seen;
    logic [15:0] bus_data_i, bus_data_o, reg_wdata, reg_rdata, rd_d, wd_seen;
    logic [4:0] base_jmp_lvl = 5'h00;
    logic [4:0] opt_jmp_lvl = 5'h0a;
    logic [2:0] flag_bits = 3'h5;
    logic [4:0] reg_offset, wo_seen;
    logic [4:0] bl [3] = '{5'h00, 5'h16, 5'h1f};
    int fail_count = 0;
    int n_compared = 0;
    int cyc = 0;
    int wr_cnt = 0;
    `define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin fail_count++; \
        $display("mismatch %s expected %h seen %h", nm, ex, gt); end end
    always #4 clock = ~clock;
    assign reg_rdata = {3'h5, reg_offset, 3'h2, reg_offset};
    iod_host_model host (.clock(clock), .bus_addr(bus_addr), .bus_aen(bus_aen),
        .bus_ior_n(bus_ior_n), .bus_iow_n(bus_iow_n), .bus_sbhe_n(bus_sbhe_n),
        .bus_data_i(bus_data_i), .bus_data_o(bus_data_o), .bus_data_oe(bus_data_oe));
    iod_decoder dut (.clock(clock), .ce(1'b1), .sys_rst(sys_rst), .bus_addr(bus_addr),
        .bus_aen(bus_aen), .bus_ior_n(bus_ior_n), .bus_iow_n(bus_iow_n),
        .bus_sbhe_n(bus_sbhe_n), .bus_data_i(bus_data_i), .bus_data_o(bus_data_o),
        .bus_data_oe(bus_data_oe), .bus_io16_n_o(io16_o), .bus_io16_n_oe(io16_oe),
        .base_jmp_lvl(base_jmp_lvl), .opt_jmp_lvl(opt_jmp_lvl), .flag_bits(flag_bits),
        .board_sel(board_sel), .reg_offset(reg_offset), .reg_word(reg_word),
        .reg_rd_stb(reg_rd_stb), .reg_wr_stb(reg_wr_stb), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata));
    task automatic results();
        if (fail_count == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clock) begin
        cyc++;
        if (reg_rd_stb) begin
            io16_seen = {io16_o, io16_oe};
        end
        if (reg_wr_stb) begin
            wr_cnt++;
            wd_seen = reg_wdata;
            wo_seen = reg_offset;
        end
        if (cyc == 5000) begin
            fail_count++;
            results();
        end
    end
    task automatic rd_chk(input logic [9:0] a, input logic word, input logic aen,
                          input logic ex_oe, input logic [15:0] ex_d);
        host.rd(a, word, aen, rd_d, rd_oe);
        `CHK("drive", ex_oe, rd_oe)
        if (ex_oe) `CHK("rdata", ex_d, rd_d)
        if (ex_oe) `CHK("io16", {1'b0, word}, io16_seen)
    endtask
    task automatic wr_chk(input logic [9:0] a, input logic word, input logic [15:0] d,
                          input int ok, input logic [15:0] ex_d);
        int n0;
        n0 = wr_cnt;
        host.wr(a, word, d);
        `CHK("wr_stb", n0 + ok, wr_cnt)
        if (ok == 1) `CHK("wdata", ex_d, wd_seen)
        if (ok == 1) `CHK("offset", a[4:0], wo_seen)
    endtask
    initial begin
        repeat (6) @(posedge clock);
        #1;
        sys_rst = 1'b0;
        for (int i = 0; i < 3; i++) begin
            base_jmp_lvl = bl[i];
            opt_jmp_lvl = bl[i] ^ 5'h0a;
            flag_bits = i[2:0];
            ba = {bl[i], 5'h00};
            rd_chk(ba + 10'h012, 0, 0, 1, {8'h00, flag_bits, opt_jmp_lvl});
            rd_chk(ba + 10'h01c, 0, 0, 0, 16'h0000);
            for (int k = 0; k < 5; k++) rd_chk(ba ^ (10'h020 << k), 0, 0, 0, 16'h0000);
        end
        rd_chk(10'h3e0, 0, 1, 0, 16'h0000);
        rd_chk(10'h3e0, 1, 0, 1, 16'ha040);
        rd_chk(10'h3fb, 0, 0, 1, 16'h005b);
        rd_chk(10'h3f1, 0, 0, 1, 16'h0051);
        rd_chk(10'h3f2, 1, 0, 1, {8'hb2, flag_bits, opt_jmp_lvl});
        wr_chk(10'h3e4, 1, 16'ha5c3, 1, 16'ha5c3);
        wr_chk(10'h3e5, 0, 16'h5a3c, 1, 16'h003c);
        wr_chk(10'h3fc, 1, 16'h1234, 0, 16'h0000);
        wr_chk(10'h3f2, 0, 16'h00ff, 0, 16'h0000);
        results();
    end
endmodule // iod_decoder_tb
